// ### inc/bsbe_pkg.sv
/*
 * Op codes, target kinds, widths and state/byte counts of the execution unit.
 * Assumes a decoder ahead of the unit that classifies each instruction.
 */
package bsbe_pkg;

    localparam int ST_W = 4;
    localparam int BY_W = 3;
    localparam int PC_W = 16;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;

    typedef enum logic [4:0] {
        OP_CLR_C, OP_SET_C, OP_CPL_C,
        OP_CLR_B, OP_SET_B, OP_CPL_B,
        OP_AND_B, OP_AND_NB, OP_OR_B, OP_OR_NB,
        OP_MOV_BC, OP_MOV_CB,
        OP_XCH_IND, OP_NIBBLE_EXCHANGE_OP_IND,
        OP_PUSH_WIDE, OP_PUSH_IMM16, OP_POP_DIR, OP_POP_HALF,
        OP_JC, OP_JNC, OP_JE, OP_JNE, OP_JG, OP_JLE,
        OP_JSL, OP_JUMP_ON_SIGNED_LESS_EQUAL, OP_JSG, OP_JUMP_ON_SIGNED_GREATER_EQUAL
    } bsbe_op_e;

    typedef enum logic [1:0] {
        TGT_RAM, TGT_PORT, TGT_PERIPH
    } bsbe_tgt_e;

    // carry-only bit ops
    localparam logic [ST_W-1:0] ST_CARRY = 4'h1;
    localparam logic [BY_W-1:0] BY_CARRY = 3'h1;
    // bit reads into carry
    localparam logic [ST_W-1:0] ST_RD_LOW = 4'h1;
    localparam logic [BY_W-1:0] BY_RD_LOW = 3'h2;
    localparam logic [ST_W-1:0] ST_RD_EXT_LEG = 4'h3;
    localparam logic [BY_W-1:0] BY_RD_EXT_LEG = 3'h4;
    localparam logic [ST_W-1:0] ST_RD_EXT_NAT = 4'h2;
    localparam logic [BY_W-1:0] BY_RD_EXT_NAT = 3'h3;
    // bit writes
    localparam logic [ST_W-1:0] ST_WR_LOW = 4'h2;
    localparam logic [BY_W-1:0] BY_WR_LOW = 3'h2;
    localparam logic [ST_W-1:0] ST_WR_EXT_LEG = 4'h4;
    localparam logic [BY_W-1:0] BY_WR_EXT_LEG = 3'h4;
    localparam logic [ST_W-1:0] ST_WR_EXT_NAT = 4'h3;
    localparam logic [BY_W-1:0] BY_WR_EXT_NAT = 3'h3;
    // access penalties
    localparam logic [ST_W-1:0] PEN_RD_PORT = 4'h1;
    localparam logic [ST_W-1:0] PEN_RD_PERI = 4'h2;
    localparam logic [ST_W-1:0] PEN_WR_PORT = 4'h2;
    localparam logic [ST_W-1:0] PEN_WR_PERI = 4'h3;
    // exchange
    localparam logic [ST_W-1:0] ST_XCH_LEG = 4'h4;
    localparam logic [BY_W-1:0] BY_XCH_LEG = 3'h1;
    localparam logic [ST_W-1:0] ST_XCH_NAT = 4'h5;
    localparam logic [BY_W-1:0] BY_XCH_NAT = 3'h2;
    // stack
    localparam logic [ST_W-1:0] ST_PUSHW_LEG = 4'h9;
    localparam logic [ST_W-1:0] ST_PUSHW_NAT = 4'h8;
    localparam logic [BY_W-1:0] BY_PUSHW_LEG = 3'h3;
    localparam logic [BY_W-1:0] BY_PUSHW_NAT = 3'h2;
    localparam logic [ST_W-1:0] ST_PUSHI = 4'h5;
    localparam logic [BY_W-1:0] BY_PUSHI_LEG = 3'h5;
    localparam logic [BY_W-1:0] BY_PUSHI_NAT = 3'h4;
    localparam logic [ST_W-1:0] ST_POPD = 4'h3;
    localparam logic [BY_W-1:0] BY_POPD = 3'h2;
    localparam logic [ST_W-1:0] ST_POPH_LEG = 4'h5;
    localparam logic [BY_W-1:0] BY_POPH_LEG = 3'h3;
    localparam logic [ST_W-1:0] ST_POPH_NAT = 4'h4;
    localparam logic [BY_W-1:0] BY_POPH_NAT = 3'h2;
    // conditional jumps, not taken / taken
    localparam logic [ST_W-1:0] ST_JC_NT = 4'h1;
    localparam logic [ST_W-1:0] ST_JC_TK = 4'h4;
    localparam logic [BY_W-1:0] BY_JC = 3'h2;
    localparam logic [ST_W-1:0] ST_JCMP_LEG_NT = 4'h2;
    localparam logic [ST_W-1:0] ST_JCMP_LEG_TK = 4'h5;
    localparam logic [BY_W-1:0] BY_JCMP_LEG = 3'h3;
    localparam logic [ST_W-1:0] ST_JCMP_NAT_NT = 4'h1;
    localparam logic [ST_W-1:0] ST_JCMP_NAT_TK = 4'h4;
    localparam logic [BY_W-1:0] BY_JCMP_NAT = 3'h2;
    localparam logic [ST_W-1:0] PEN_ODD_DEST = 4'h1;
    localparam logic [ST_W-1:0] ST_DEC = 4'h1;

endpackage

// ### inc/bsbe_timing_if.sv
/*
 * Carries one instruction's class and context to the timing calculator
 * and its state and byte counts back. Assumes a single clock domain.
 */
`timescale 1ns/10ps
interface bsbe_timing_if;
    import bsbe_pkg::*;
    bsbe_op_e op;
    logic nativeMode;
    logic extBit;
    bsbe_tgt_e target;
    logic taken;
    logic oddDest;
    logic [ST_W-1:0] states;
    logic [BY_W-1:0] bytes;

    modport calc (input op, nativeMode, extBit, target, taken, oddDest,
                  output states, bytes);
    modport user (output op, nativeMode, extBit, target, taken, oddDest,
                  input states, bytes);
endinterface

// ### rtl/bsbe_timing.sv
/*
 * State and byte count of one instruction, purely combinational.
 * Assumes the caller has resolved taken and destination parity.
 */
`timescale 1ns/10ps
module bsbe_timing
(
    // instruction context and result
    bsbe_timing_if.calc tif
);
    import bsbe_pkg::*;

    logic [ST_W-1:0] base;
    logic [ST_W-1:0] pen;
    logic [ST_W-1:0] rdPen;
    logic [ST_W-1:0] wrPen;

    // ========================================
    // penalties by target kind
    always_comb
    begin
        rdPen = (tif.target == TGT_PORT) ? PEN_RD_PORT :
                (tif.target == TGT_PERIPH) ? PEN_RD_PERI : '0;
        wrPen = (tif.target == TGT_PORT) ? PEN_WR_PORT :
                (tif.target == TGT_PERIPH) ? PEN_WR_PERI : '0;
    end

    // ========================================
    // base counts
    always_comb
    begin
        base = ST_CARRY;
        pen = '0;
        tif.bytes = BY_CARRY;
        case (tif.op)
            OP_CLR_C, OP_SET_C, OP_CPL_C:
            begin
                base = ST_CARRY;
                tif.bytes = BY_CARRY;
            end
            OP_CLR_B, OP_SET_B, OP_CPL_B, OP_MOV_BC:
            begin
                base = !tif.extBit ? ST_WR_LOW :
                       (tif.nativeMode ? ST_WR_EXT_NAT : ST_WR_EXT_LEG);
                tif.bytes = !tif.extBit ? BY_WR_LOW :
                       (tif.nativeMode ? BY_WR_EXT_NAT : BY_WR_EXT_LEG);
                pen = wrPen;
            end
            OP_AND_B, OP_AND_NB, OP_OR_B, OP_OR_NB, OP_MOV_CB:
            begin
                base = !tif.extBit ? ST_RD_LOW :
                       (tif.nativeMode ? ST_RD_EXT_NAT : ST_RD_EXT_LEG);
                tif.bytes = !tif.extBit ? BY_RD_LOW :
                       (tif.nativeMode ? BY_RD_EXT_NAT : BY_RD_EXT_LEG);
                pen = rdPen;
            end
            OP_XCH_IND, OP_NIBBLE_EXCHANGE_OP_IND:
            begin
                base = tif.nativeMode ? ST_XCH_NAT : ST_XCH_LEG;
                tif.bytes = tif.nativeMode ? BY_XCH_NAT : BY_XCH_LEG;
            end
            OP_PUSH_WIDE:
            begin
                base = tif.nativeMode ? ST_PUSHW_NAT : ST_PUSHW_LEG;
                tif.bytes = tif.nativeMode ? BY_PUSHW_NAT : BY_PUSHW_LEG;
            end
            OP_PUSH_IMM16:
            begin
                base = ST_PUSHI;
                tif.bytes = tif.nativeMode ? BY_PUSHI_NAT : BY_PUSHI_LEG;
            end
            OP_POP_DIR:
            begin
                base = ST_POPD;
                tif.bytes = BY_POPD;
                pen = rdPen;
            end
            OP_POP_HALF:
            begin
                base = tif.nativeMode ? ST_POPH_NAT : ST_POPH_LEG;
                tif.bytes = tif.nativeMode ? BY_POPH_NAT : BY_POPH_LEG;
            end
            OP_JC, OP_JNC:
            begin
                base = tif.taken ? ST_JC_TK : ST_JC_NT;
                tif.bytes = BY_JC;
            end
            OP_JE, OP_JNE, OP_JG, OP_JLE, OP_JSL, OP_JUMP_ON_SIGNED_LESS_EQUAL, OP_JSG, OP_JUMP_ON_SIGNED_GREATER_EQUAL:
            begin
                if (tif.nativeMode)
                begin
                    base = tif.taken ? ST_JCMP_NAT_TK : ST_JCMP_NAT_NT;
                    tif.bytes = BY_JCMP_NAT;
                end
                else
                begin
                    base = tif.taken ? ST_JCMP_LEG_TK : ST_JCMP_LEG_NT;
                    tif.bytes = BY_JCMP_LEG;
                end
            end
            default:
            begin
                base = ST_CARRY;
                tif.bytes = BY_CARRY;
            end
        endcase
        // odd internal destination only costs when the jump is taken
        if (tif.taken && tif.oddDest)
        begin
            pen = PEN_ODD_DEST;
        end
        tif.states = base + pen;
    end

endmodule

// ### rtl/bsbe_exec.sv
/*
 * Bit, exchange, stack and conditional jump execution unit.
 * Holds carry and accumulator, computes results,
 * stays busy for the instruction's state count.
 * Assumes a same-clock decoder giving one instruction per
 * startReq pulse while busy is low, operands valid then.
 */
`timescale 1ns/10ps
module bsbe_exec
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // instruction request
    input wire logic startReq,
    input wire bsbe_pkg::bsbe_op_e opCode,
    input wire logic nativeMode,
    input wire logic extBit,
    input wire bsbe_pkg::bsbe_tgt_e target,
    // operands
    input wire logic srcBit,
    input wire logic [bsbe_pkg::DATA_W-1:0] memByte,
    input wire logic [bsbe_pkg::PC_W-1:0] pcIn,
    input wire logic [bsbe_pkg::DATA_W-1:0] relOffset,
    // compare flags
    input wire logic cmpZero,
    input wire logic cmpNeg,
    input wire logic cmpOvf,
    // execution context
    input wire logic internalExec,
    input wire logic destInternal,
    // status
    output logic busy,
    output logic done,
    output logic carryFlag,
    output logic [bsbe_pkg::DATA_W-1:0] accumulatorValue,
    // bit and memory write-back
    output logic bitOut,
    output logic bitWrite,
    output logic [bsbe_pkg::DATA_W-1:0] memOut,
    output logic memWrite,
    // flow and timing
    output logic [bsbe_pkg::PC_W-1:0] pcOut,
    output logic jumpTaken,
    output logic [bsbe_pkg::ST_W-1:0] stateCount,
    output logic [bsbe_pkg::BY_W-1:0] byteCount
);
    import bsbe_pkg::*;

    typedef enum logic {
        FSM_IDLE,
        FSM_EXEC
    } bsbe_fsm_e;

    typedef struct packed {
        bsbe_fsm_e fsm;
        logic [ST_W-1:0] cnt;
        logic busy;
        logic done;
        logic carry;
        logic [DATA_W-1:0] acc;
        logic pendCarry;
        logic [DATA_W-1:0] pendAcc;
        logic pendBitWe;
        logic pendMemWe;
        logic bitOut;
        logic bitWe;
        logic [DATA_W-1:0] memOut;
        logic memWe;
        logic [PC_W-1:0] pc;
        logic taken;
        logic [ST_W-1:0] states;
        logic [BY_W-1:0] bytes;
    } bsbe_state_s;

    bsbe_state_s state_reg;
    bsbe_state_s state_next;

    bsbe_timing_if tif();

    logic condTrue;
    logic signedLess;
    logic [PC_W-1:0] pcSeq;
    logic [PC_W-1:0] pcTarget;

    // ========================================
    // jump condition
    always_comb
    begin
        signedLess = cmpNeg ^ cmpOvf;
        case (opCode)
            OP_JC: condTrue = state_reg.carry;
            OP_JNC: condTrue = !state_reg.carry;
            OP_JE: condTrue = cmpZero;
            OP_JNE: condTrue = !cmpZero;
            OP_JG: condTrue = !state_reg.carry && !cmpZero;
            OP_JLE: condTrue = state_reg.carry || cmpZero;
            OP_JSL: condTrue = signedLess;
            OP_JUMP_ON_SIGNED_LESS_EQUAL: condTrue = signedLess || cmpZero;
            OP_JSG: condTrue = !signedLess && !cmpZero;
            OP_JUMP_ON_SIGNED_GREATER_EQUAL: condTrue = !signedLess;
            default: condTrue = 1'b0;
        endcase
    end

    // ========================================
    // program counter arithmetic
    always_comb
    begin
        pcSeq = pcIn + PC_W'(tif.bytes);
        // offset is sign-extended; wraps modulo the counter width
        pcTarget = condTrue ?
            pcSeq + {{(PC_W-DATA_W){relOffset[DATA_W-1]}}, relOffset} : pcSeq;
    end

    // ========================================
    // timing calculator
    assign tif.op = opCode;
    assign tif.nativeMode = nativeMode;
    assign tif.extBit = extBit;
    assign tif.target = target;
    assign tif.taken = condTrue;
    assign tif.oddDest = internalExec && destInternal && pcTarget[0];

    bsbe_timing u_timing
    (
        .tif(tif)
    );

    // ========================================
    // next state
    always_comb
    begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.bitWe = 1'b0;
        state_next.memWe = 1'b0;
        case (state_reg.fsm)
            FSM_IDLE:
            begin
                // requests while busy are not looked at
                if (startReq)
                begin
                    state_next.fsm = FSM_EXEC;
                    state_next.busy = 1'b1;
                    state_next.cnt = tif.states - ST_DEC;
                    state_next.states = tif.states;
                    state_next.bytes = tif.bytes;
                    state_next.pc = pcTarget;
                    state_next.taken = condTrue;
                    state_next.pendCarry = state_reg.carry;
                    state_next.pendAcc = state_reg.acc;
                    state_next.pendBitWe = 1'b0;
                    state_next.pendMemWe = 1'b0;
                    state_next.bitOut = srcBit;
                    state_next.memOut = memByte;
                    case (opCode)
                        OP_CLR_C: state_next.pendCarry = 1'b0;
                        OP_SET_C: state_next.pendCarry = 1'b1;
                        OP_CPL_C: state_next.pendCarry = !state_reg.carry;
                        OP_CLR_B:
                        begin
                            state_next.bitOut = 1'b0;
                            state_next.pendBitWe = 1'b1;
                        end
                        OP_SET_B:
                        begin
                            state_next.bitOut = 1'b1;
                            state_next.pendBitWe = 1'b1;
                        end
                        OP_CPL_B:
                        begin
                            state_next.bitOut = !srcBit;
                            state_next.pendBitWe = 1'b1;
                        end
                        OP_AND_B: state_next.pendCarry = state_reg.carry & srcBit;
                        OP_AND_NB: state_next.pendCarry = state_reg.carry & !srcBit;
                        OP_OR_B: state_next.pendCarry = state_reg.carry | srcBit;
                        OP_OR_NB: state_next.pendCarry = state_reg.carry | !srcBit;
                        OP_MOV_CB: state_next.pendCarry = srcBit;
                        OP_MOV_BC:
                        begin
                            state_next.bitOut = state_reg.carry;
                            state_next.pendBitWe = 1'b1;
                        end
                        OP_XCH_IND:
                        begin
                            state_next.pendAcc = memByte;
                            state_next.memOut = state_reg.acc;
                            state_next.pendMemWe = 1'b1;
                        end
                        OP_NIBBLE_EXCHANGE_OP_IND:
                        begin
                            // high nibbles of both stay put
                            state_next.pendAcc =
                                {state_reg.acc[DATA_W-1:NIB_W], memByte[NIB_W-1:0]};
                            state_next.memOut =
                                {memByte[DATA_W-1:NIB_W], state_reg.acc[NIB_W-1:0]};
                            state_next.pendMemWe = 1'b1;
                        end
                        OP_POP_DIR:
                        begin
                            state_next.memOut = memByte;
                            state_next.pendMemWe = 1'b1;
                        end
                        default:
                        begin
                            state_next.pendMemWe = 1'b0;
                        end
                    endcase
                end
            end
            FSM_EXEC:
            begin
                if (state_reg.cnt == '0)
                begin
                    // carry, accumulator and write strobes land together on the last edge; bitOut and memOut were set on the taking edge
                    state_next.fsm = FSM_IDLE;
                    state_next.busy = 1'b0;
                    state_next.done = 1'b1;
                    state_next.carry = state_reg.pendCarry;
                    state_next.acc = state_reg.pendAcc;
                    state_next.bitWe = state_reg.pendBitWe;
                    state_next.memWe = state_reg.pendMemWe;
                end
                else
                begin
                    state_next.cnt = state_reg.cnt - ST_DEC;
                end
            end
            default:
            begin
                state_next = '0;
            end
        endcase
    end

    // ========================================
    // state register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ========================================
    // outputs straight from the state register
    assign busy = state_reg.busy;
    assign done = state_reg.done;
    assign carryFlag = state_reg.carry;
    assign accumulatorValue = state_reg.acc;
    assign bitOut = state_reg.bitOut;
    assign bitWrite = state_reg.bitWe;
    assign memOut = state_reg.memOut;
    assign memWrite = state_reg.memWe;
    assign pcOut = state_reg.pc;
    assign jumpTaken = state_reg.taken;
    assign stateCount = state_reg.states;
    assign byteCount = state_reg.bytes;

endmodule

// ### sim/bsbe_exec_chk.sv
/*
 * Checker for bsbe_exec: timing, carry, exchange and jump relations.
 * Assumes bsbe_pkg is compiled first; bound to bsbe_exec at the foot.
 */
`timescale 1ns/10ps
module bsbe_exec_chk
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // request
    input wire logic startReq,
    input wire bsbe_pkg::bsbe_op_e opCode,
    input wire logic nativeMode,
    input wire logic extBit,
    input wire bsbe_pkg::bsbe_tgt_e target,
    input wire logic srcBit,
    input wire logic [bsbe_pkg::PC_W-1:0] pcIn,
    input wire logic [bsbe_pkg::DATA_W-1:0] relOffset,
    input wire logic internalExec,
    input wire logic destInternal,
    // results
    input wire logic busy,
    input wire logic done,
    input wire logic carryFlag,
    input wire logic [bsbe_pkg::DATA_W-1:0] accumulatorValue,
    input wire logic [bsbe_pkg::DATA_W-1:0] memOut,
    input wire logic [bsbe_pkg::PC_W-1:0] pcOut,
    input wire logic jumpTaken,
    input wire logic [bsbe_pkg::ST_W-1:0] stateCount,
    input wire logic [bsbe_pkg::BY_W-1:0] byteCount
);
    import bsbe_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ========================================
    // helpers
    logic take;
    logic [PC_W-1:0] relExt;
    logic [3:0] busyCnt_reg;
    assign take = startReq && !busy;
    assign relExt = {{8{relOffset[7]}}, relOffset};
    // busy cycles since taking; restarts on a back-to-back take
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || take)
            busyCnt_reg <= 4'h0;
        else if (busy)
            busyCnt_reg <= busyCnt_reg + 4'h1;
    end
    sequence sOneState;
        ##1 busy ##1 done;
    endsequence
    // ========================================
    // assertions
    chk_done_timing: assert property (done |-> busyCnt_reg == stateCount)
        else $error("done timing wrong");
    chk_cpl_carry: assert property (take && opCode == OP_CPL_C |->
        sOneState ##0 carryFlag != $past(carryFlag, 2)) else $error("carry not inverted");
    chk_and_carry: assert property (take && opCode == OP_AND_B && !extBit &&
        target == TGT_RAM |-> sOneState ##0 carryFlag == ($past(carryFlag, 2) &
        $past(srcBit, 2))) else $error("and into carry wrong");
    chk_read_pen: assert property (take && opCode == OP_MOV_CB && !extBit |=>
        stateCount == 4'h1 + 4'($past(target))) else $error("read penalty wrong");
    chk_write_pen: assert property (take && opCode == OP_MOV_BC && !extBit &&
        target == TGT_PORT |=> stateCount == 4'h4 && byteCount == 3'h2)
        else $error("write penalty wrong");
    chk_xch_swap: assert property (take && opCode == OP_XCH_IND |=>
        memOut == $past(accumulatorValue) && stateCount == ($past(nativeMode) ? 4'h5 : 4'h4))
        else $error("exchange wrong");
    chk_carry_jump: assert property (take && opCode inside {OP_JC, OP_JNC} &&
        !internalExec |=> jumpTaken == ($past(carryFlag) ^ ($past(opCode) == OP_JNC)) &&
        stateCount == (jumpTaken ? 4'h4 : 4'h1)) else $error("carry jump wrong");
    chk_cmp_jump: assert property (take && opCode inside {[OP_JE:OP_JUMP_ON_SIGNED_GREATER_EQUAL]} &&
        !internalExec |=> byteCount == ($past(nativeMode) ? 3'h2 : 3'h3) &&
        stateCount == (jumpTaken ? 4'h4 : 4'h1) + {3'h0, !$past(nativeMode)})
        else $error("compare jump wrong");
    chk_pc_next: assert property (take && opCode inside {[OP_JC:OP_JUMP_ON_SIGNED_GREATER_EQUAL]} |=>
        pcOut == $past(pcIn) + 16'(byteCount) + (jumpTaken ? $past(relExt) : 16'h0000))
        else $error("next pc wrong");
    chk_odd_pen: assert property (take && opCode == OP_JC && internalExec &&
        destInternal |=> stateCount == (jumpTaken ? 4'h4 + {3'h0, pcOut[0]} : 4'h1))
        else $error("odd penalty wrong");
endmodule
bind bsbe_exec bsbe_exec_chk i_chk (.ref_clk, .rst_n, .startReq, .opCode, .nativeMode,
    .extBit, .target, .srcBit, .pcIn, .relOffset, .internalExec, .destInternal, .busy,
    .done, .carryFlag, .accumulatorValue, .memOut, .pcOut, .jumpTaken, .stateCount,
    .byteCount);

// ### sim/test_bsbe_exec.sv
/*
 * Self-checking bench for bsbe_exec, one task per scenario.
 * Assumes bsbe_pkg and the checker compiled first.
 */
`timescale 1ns/10ps
module test_bsbe_exec;
    import bsbe_pkg::*;
    // ========================================
    // signals
    logic ref_clk, rst_n, startReq, nativeMode, extBit, srcBit, cmpZero, cmpNeg, cmpOvf;
    logic internalExec, destInternal, busy, done, carryFlag, bitOut, bitWrite, memWrite;
    logic jumpTaken;
    bsbe_op_e opCode;
    bsbe_tgt_e target;
    logic [DATA_W-1:0] memByte, relOffset, accumulatorValue, memOut;
    logic [PC_W-1:0] pcIn, pcOut;
    logic [ST_W-1:0] stateCount;
    logic [BY_W-1:0] byteCount;
    int mismatches, checks;
    bsbe_exec i_dut (.ref_clk, .rst_n, .startReq, .opCode, .nativeMode, .extBit, .target,
        .srcBit, .memByte, .pcIn, .relOffset, .cmpZero, .cmpNeg, .cmpOvf, .internalExec,
        .destInternal, .busy, .done, .carryFlag, .accumulatorValue, .bitOut, .bitWrite,
        .memOut, .memWrite, .pcOut, .jumpTaken, .stateCount, .byteCount);
    initial
    begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ========================================
    // shared tasks
    task automatic check(input logic [15:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one instruction; counts edges from taking to done
    task automatic run(input bsbe_op_e op, input logic [3:0] st);
        int n;
        @(posedge ref_clk);
        opCode <= op;
        startReq <= 1'h1;
        @(posedge ref_clk);
        startReq <= 1'h0;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while (done !== 1'h1 && n < 20);
        check(n, st);
        check(stateCount, st);
    endtask
    function automatic logic cond(bsbe_op_e op, logic c, logic z, logic n, logic v);
        case (op)
            OP_JC: return c;
            OP_JNC: return !c;
            OP_JE: return z;
            OP_JNE: return !z;
            OP_JG: return !c && !z;
            OP_JLE: return c || z;
            OP_JSL: return n ^ v;
            OP_JUMP_ON_SIGNED_LESS_EQUAL: return (n ^ v) || z;
            OP_JSG: return !((n ^ v) || z);
            default: return !(n ^ v);
        endcase
    endfunction
    // ========================================
    // scenarios
    task automatic t_carry();
        run(OP_SET_C, 4'h1);
        check(carryFlag, 1'h1);
        run(OP_CLR_C, 4'h1);
        check(carryFlag, 1'h0);
        run(OP_CPL_C, 4'h1);
        check(carryFlag, 1'h1);
    endtask
    task automatic t_logic();
        bsbe_op_e ops[5] = '{OP_AND_B, OP_AND_NB, OP_OR_B, OP_OR_NB, OP_MOV_CB};
        logic e;
        for (int k = 0; k < 20; k++)
        begin
            run(k[0] ? OP_SET_C : OP_CLR_C, 4'h1);
            @(posedge ref_clk);
            srcBit <= k[1];
            e = (k > 15) ? k[1] : k[3] ? k[0] | (k[1] ^ k[2]) : k[0] & (k[1] ^ k[2]);
            run(ops[k / 4], 4'h1);
            check(carryFlag, e);
            check(bitWrite, 1'h0);
        end
    endtask
    task automatic t_bit_time();
        logic [3:0] st, pr;
        logic [2:0] by;
        for (int k = 0; k < 12; k++)
        begin
            @(posedge ref_clk);
            extBit <= k[0];
            nativeMode <= k[1];
            target <= bsbe_tgt_e'(k / 4);
            st = !k[0] ? 4'h1 : k[1] ? 4'h2 : 4'h3;
            by = !k[0] ? 3'h2 : k[1] ? 3'h3 : 3'h4;
            pr = 4'(k / 4);
            run(OP_AND_NB, st + pr);
            check(byteCount, by);
            run(OP_MOV_CB, st + pr);
            run(OP_MOV_BC, st + 4'h1 + pr + (pr != 4'h0));
            check(byteCount, by);
        end
    endtask
    task automatic t_bit_write();
        bsbe_op_e ops[4] = '{OP_CLR_B, OP_SET_B, OP_CPL_B, OP_MOV_BC};
        run(OP_SET_C, 4'h1);
        @(posedge ref_clk);
        {srcBit, extBit} <= 2'h0;
        target <= TGT_RAM;
        for (int k = 0; k < 4; k++)
        begin
            run(ops[k], 4'h2);
            check(bitOut, k != 0);
            check(bitWrite, 1'h1);
        end
    endtask
    task automatic t_xch();
        @(posedge ref_clk);
        nativeMode <= 1'h0;
        memByte <= 8'hA5;
        run(OP_XCH_IND, 4'h4);
        check({accumulatorValue, memOut}, 16'hA500);
        check({memWrite, byteCount}, 4'h9);
        @(posedge ref_clk);
        nativeMode <= 1'h1;
        memByte <= 8'h3C;
        run(OP_NIBBLE_EXCHANGE_OP_IND, 4'h5);
        check({accumulatorValue, memOut}, 16'hAC35);
        @(posedge ref_clk);
        memByte <= 8'h5A;
        run(OP_XCH_IND, 4'h5);
        check({accumulatorValue, memOut}, 16'h5AAC);
        check(byteCount, 3'h2);
    endtask
    task automatic t_stack();
        for (int m = 0; m < 2; m++)
        begin
            @(posedge ref_clk);
            nativeMode <= m[0];
            target <= TGT_PERIPH;
            memByte <= 8'h69;
            run(OP_PUSH_WIDE, m ? 4'h8 : 4'h9);
            run(OP_PUSH_IMM16, 4'h5);
            check(byteCount, m ? 3'h4 : 3'h5);
            run(OP_POP_HALF, m ? 4'h4 : 4'h5);
            check(byteCount, m ? 3'h2 : 3'h3);
            run(OP_POP_DIR, 4'h5);
            check({memWrite, memOut}, 9'h169);
        end
    endtask
    task automatic t_jump();
        bsbe_op_e op;
        logic t;
        logic [2:0] len;
        logic [7:0] r;
        logic [15:0] p;
        for (int k = 0; k < 320; k++)
        begin
            op = bsbe_op_e'(OP_JC + k / 32);
            r = 8'(k * 37);
            p = 16'(k * 613);
            run(k[0] ? OP_SET_C : OP_CLR_C, 4'h1);
            @(posedge ref_clk);
            {cmpOvf, cmpNeg, cmpZero} <= k[3:1];
            nativeMode <= k[4];
            pcIn <= p;
            relOffset <= r;
            t = cond(op, k[0], k[1], k[2], k[3]);
            len = (op inside {OP_JC, OP_JNC} || k[4]) ? 3'h2 : 3'h3;
            run(op, (t ? 4'h4 : 4'h1) + 4'(len == 3'h3));
            check(jumpTaken, t);
            check(byteCount, len);
            check(pcOut, p + 16'(len) + (t ? {{8{r[7]}}, r} : 16'h0000));
        end
    endtask
    // odd target: taken, internal run and destination
    task automatic t_odd();
        run(OP_SET_C, 4'h1);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge ref_clk);
            internalExec <= 1'h1;
            destInternal <= (k != 2);
            pcIn <= (k == 3) ? 16'h1001 : 16'h1000;
            relOffset <= (k == 0) ? 8'h02 : 8'h03;
            run((k == 3) ? OP_JNC : OP_JC, (k == 1) ? 4'h5 : (k == 3) ? 4'h1 : 4'h4);
        end
    endtask
    // ========================================
    // main sequence and watchdog
    initial
    begin
        {rst_n, startReq, nativeMode, extBit, srcBit, cmpZero, cmpNeg, cmpOvf} = 8'h00;
        {internalExec, destInternal, memByte, relOffset, pcIn} = 34'h0;
        opCode = OP_CLR_C;
        target = TGT_RAM;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'h1;
        t_carry();
        t_logic();
        t_bit_time();
        t_bit_write();
        t_xch();
        t_stack();
        t_jump();
        t_odd();
        end_sim();
    end
    initial
    begin
        #600000;
        mismatches++;
        end_sim();
    end
endmodule
